// ===== src/sac_adc_ctrl.sv
// Control, trigger sequencing and result formatting of the converter.
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_adc_ctrl
   import sac_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Special function register bus.
   input wire sac_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // Conversion triggers.
   input wire logic timer3_ovf,
   input wire logic timer2_ovf,
   input wire logic external_convert_start,
   // Qualifiers from neighbouring logic.
   input wire logic diff_mode,
   input wire logic window_hit,
   input wire logic conv_irq_en,
   // Analog converter.
   input wire logic [9:0] sar_data,
   output sac_ana_t ana_ctl,
   // Results and interrupt.
   output logic [15:0] result_word,
   output logic conv_irq
);

   // ========================================
   // Declarations
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic ext_rise;
   logic [7:0] cfg_q;
   logic [7:0] cfg_d;
   logic en_q;
   logic en_d;
   logic tm_q;
   logic tm_d;
   logic done_q;
   logic done_d;
   logic [1:0] src_q;
   logic [1:0] src_d;
   logic win_q;
   logic win_d;
   logic lj_q;
   logic lj_d;
   logic [7:0] res_hi_q;
   logic [7:0] res_hi_d;
   logic [7:0] res_lo_q;
   logic [7:0] res_lo_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic irq_q;
   logic irq_d;
   sac_state_t state_q;
   sac_state_t state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic wr_cfg;
   logic wr_ctl;
   logic wr_low;
   logic wr_high;
   logic trig;
   logic start;
   logic finish;
   logic busy;
   logic tick;
   logic [7:0] fmt_hi;
   logic [7:0] fmt_lo;

   // ========================================
   // External start pin synchroniser
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end
      else if (ce)
      begin
         ext_s1_q <= external_convert_start;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_rise = ext_s2_q && !ext_s3_q;

   // ========================================
   // Conversion clock divider
   sac_clk_div u_div (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .run(en_q || busy),
      .div(cfg_q[`SAC_CFG_DIV]),
      .tick(tick)
   );

   // ========================================
   // Trigger selection
   always_comb
   begin
      wr_cfg = sfr_req.wr && (sfr_req.addr == `SAC_ADDR_CFG);
      wr_ctl = sfr_req.wr && (sfr_req.addr == `SAC_ADDR_CTL);
      wr_low = sfr_req.wr && (sfr_req.addr == `SAC_ADDR_LOW);
      wr_high = sfr_req.wr && (sfr_req.addr == `SAC_ADDR_HIGH);
      busy = (state_q != ST_IDLE);
      case (src_q)
         `SAC_SRC_SW: trig = wr_ctl && sfr_req.wdata[`SAC_CTL_BUSY];
         `SAC_SRC_T3: trig = timer3_ovf;
         `SAC_SRC_EXT: trig = ext_rise;
         default: trig = timer2_ovf;
      endcase
      start = en_q && trig && !busy;
   end

   // ========================================
   // Track and convert sequencer
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      finish = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            cnt_d = 4'h0;
            if (start && tm_q && (src_q != `SAC_SRC_EXT))
            begin
               state_d = ST_TRACK;
            end
            else if (start)
            begin
               state_d = ST_CONV;
            end
         end
         ST_TRACK:
         begin
            if (tick && (cnt_q == `SAC_TRACK_TICKS - 4'h1))
            begin
               state_d = ST_CONV;
               cnt_d = 4'h0;
            end
            else if (tick)
            begin
               cnt_d = cnt_q + 4'h1;
            end
         end
         ST_CONV:
         begin
            if (tick && (cnt_q == `SAC_CONV_TICKS - 4'h1))
            begin
               state_d = ST_IDLE;
               cnt_d = 4'h0;
               finish = 1'b1;
            end
            else if (tick)
            begin
               cnt_d = cnt_q + 4'h1;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
            cnt_d = 4'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
      end
      else if (ce)
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // ========================================
   // Result formatting
   always_comb
   begin
      if (lj_q)
      begin
         fmt_hi = sar_data[9:2];
         fmt_lo = {sar_data[1:0], 6'h00};
      end
      else
      begin
         fmt_hi = {{6{diff_mode && sar_data[9]}}, sar_data[9:8]};
         fmt_lo = sar_data[7:0];
      end
   end

   // ========================================
   // Register file
   always_comb
   begin
      cfg_d = wr_cfg ? (sfr_req.wdata & `SAC_CFG_WMASK) : cfg_q;
      en_d = wr_ctl ? sfr_req.wdata[`SAC_CTL_EN] : en_q;
      tm_d = wr_ctl ? sfr_req.wdata[`SAC_CTL_TM] : tm_q;
      src_d = wr_ctl ? sfr_req.wdata[`SAC_CTL_SRC] : src_q;
      lj_d = wr_ctl ? sfr_req.wdata[`SAC_CTL_LJ] : lj_q;
      done_d = wr_ctl ? sfr_req.wdata[`SAC_CTL_DONE] : done_q;
      if (finish)
      begin
         done_d = 1'b1;
      end
      win_d = wr_ctl ? sfr_req.wdata[`SAC_CTL_WIN] : win_q;
      if (window_hit)
      begin
         win_d = 1'b1;
      end
      res_hi_d = wr_high ? sfr_req.wdata : res_hi_q;
      res_lo_d = wr_low ? sfr_req.wdata : res_lo_q;
      if (finish)
      begin
         res_hi_d = fmt_hi;
         res_lo_d = fmt_lo;
      end
      irq_d = finish && conv_irq_en;
      rdata_d = rdata_q;
      if (sfr_req.rd)
      begin
         case (sfr_req.addr)
            `SAC_ADDR_CFG: rdata_d = cfg_q;
            `SAC_ADDR_LOW: rdata_d = res_lo_q;
            `SAC_ADDR_HIGH: rdata_d = res_hi_q;
            `SAC_ADDR_CTL: rdata_d = {en_q, tm_q, done_q, busy, src_q,
                                      win_q, lj_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cfg_q <= `SAC_CFG_RST;
         en_q <= 1'b0;
         tm_q <= 1'b0;
         done_q <= 1'b0;
         src_q <= `SAC_SRC_SW;
         win_q <= 1'b0;
         lj_q <= 1'b0;
         res_hi_q <= `SAC_RES_RST;
         res_lo_q <= `SAC_RES_RST;
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
      end
      else if (ce)
      begin
         cfg_q <= cfg_d;
         en_q <= en_d;
         tm_q <= tm_d;
         done_q <= done_d;
         src_q <= src_d;
         win_q <= win_d;
         lj_q <= lj_d;
         res_hi_q <= res_hi_d;
         res_lo_q <= res_lo_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   // ========================================
   // Analog controls
   always_comb
   begin
      ana_ctl.pwr_on = en_q || busy;
      ana_ctl.sar_tick = tick && (state_q == ST_CONV);
      ana_ctl.conv_start = (state_q != ST_CONV) && (state_d == ST_CONV);
      if (!en_q && !busy)
      begin
         ana_ctl.track = 1'b0;
      end
      else if (!tm_q)
      begin
         ana_ctl.track = (state_q != ST_CONV);
      end
      else if (src_q == `SAC_SRC_EXT)
      begin
         ana_ctl.track = !ext_s2_q && (state_q == ST_IDLE);
      end
      else
      begin
         ana_ctl.track = (state_q == ST_TRACK);
      end
      ana_ctl.lp_hold = ana_ctl.pwr_on && tm_q && (state_q == ST_IDLE)
                        && !ana_ctl.track;
      case (cfg_q[`SAC_CFG_GAIN])
         3'h0: ana_ctl.gain_sel = 6'h01;
         3'h1: ana_ctl.gain_sel = 6'h02;
         3'h2: ana_ctl.gain_sel = 6'h04;
         3'h3: ana_ctl.gain_sel = 6'h08;
         3'h4, 3'h5: ana_ctl.gain_sel = 6'h10;
         default: ana_ctl.gain_sel = 6'h20;
      endcase
   end

   assign sfr_rdata = rdata_q;
   assign result_word = {res_hi_q, res_lo_q};
   assign conv_irq = irq_q;

endmodule // sac_adc_ctrl

// ===== src/sac_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ========================================
// Register offsets
`define SAC_ADDR_CFG 8'hBC
`define SAC_ADDR_LOW 8'hBE
`define SAC_ADDR_HIGH 8'hBF
`define SAC_ADDR_CTL 8'hE8

// ========================================
// Reset values and masks
`define SAC_CFG_RST 8'h60
`define SAC_CTL_RST 8'h00
`define SAC_RES_RST 8'h00
`define SAC_CFG_WMASK 8'hE7

// ========================================
// Configuration fields
`define SAC_CFG_DIV 7:5
`define SAC_CFG_GAIN 2:0

// ========================================
// Control fields
`define SAC_CTL_EN 7
`define SAC_CTL_TM 6
`define SAC_CTL_DONE 5
`define SAC_CTL_BUSY 4
`define SAC_CTL_SRC 3:2
`define SAC_CTL_WIN 1
`define SAC_CTL_LJ 0

// ========================================
// Start source codes
`define SAC_SRC_SW 2'h0
`define SAC_SRC_T3 2'h1
`define SAC_SRC_EXT 2'h2
`define SAC_SRC_T2 2'h3

// ========================================
// Timing counts in conversion clocks
`define SAC_TRACK_TICKS 4'h3
`define SAC_CONV_TICKS 4'hB

`endif

// ===== src/sac_pkg.sv
// Types shared by the converter control logic.
package sac_pkg;

   // ========================================
   // Register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sac_sfr_req_t;

   // ========================================
   // Controls toward the analog converter
   typedef struct packed {
      logic pwr_on;
      logic track;
      logic lp_hold;
      logic sar_tick;
      logic conv_start;
      logic [5:0] gain_sel;
   } sac_ana_t;

   // ========================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRACK,
      ST_CONV
   } sac_state_t;

endpackage

// ===== src/sac_clk_div.sv
// Conversion clock divider producing one tick per conversion clock.
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_clk_div
   import sac_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Divider control.
   input wire logic run,
   input wire logic [2:0] div,
   // Conversion clock tick.
   output logic tick
);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] limit;

   // ========================================
   // Divide ratio
   always_comb
   begin
      case (div)
         3'h0: limit = 4'h0;
         3'h1: limit = 4'h1;
         3'h2: limit = 4'h3;
         3'h3: limit = 4'h7;
         default: limit = 4'hF;
      endcase
      tick = run && (cnt_q == limit);
      if (!run || tick)
      begin
         cnt_d = 4'h0;
      end
      else
      begin
         cnt_d = cnt_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cnt_q <= 4'h0;
      end
      else if (ce)
      begin
         cnt_q <= cnt_d;
      end
   end

endmodule // sac_clk_div

// ===== bench/sac_ana_model.sv
// Behavioural analog converter returning a preset code.
`timescale 1ns/1ps
module sac_ana_model
   import sac_pkg::*;
(
   // Controls from the block.
   input wire sac_ana_t ana_ctl,
   // Code to hand back.
   input wire logic [9:0] code,
   // Data toward the block.
   output logic [9:0] sar_data
);
   // ========================================
   // Unpowered lines show no stale code.
   assign sar_data = ana_ctl.pwr_on ? code : ~code;
endmodule // sac_ana_model

// ===== bench/sac_adc_ctrl_sva.sv
// Property checker for the converter control block.
`timescale 1ns/1ps
module sac_adc_ctrl_sva
   import sac_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Register bus.
   input wire sac_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   // Converter and interrupt.
   input wire logic conv_irq_en,
   input wire sac_ana_t ana_ctl,
   input wire logic conv_irq
);
   // ========================================
   // Properties
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence s_rd_cfg;
      ce && sfr_req.rd && sfr_req.addr == 8'hBC;
   endsequence
   sequence s_fin;
      conv_irq ##1 !conv_irq;
   endsequence
   property p_gain;
      $onehot(ana_ctl.gain_sel);
   endproperty
   property p_cfg_gap;
      s_rd_cfg |=> sfr_rdata[4:3] == 2'h0;
   endproperty
   property p_off;
      !ana_ctl.pwr_on |-> !ana_ctl.sar_tick && !ana_ctl.track;
   endproperty
   property p_conv_hold;
      ana_ctl.sar_tick |-> !ana_ctl.track;
   endproperty
   property p_lp;
      ana_ctl.lp_hold |-> !ana_ctl.track;
   endproperty
   property p_tick;
      ana_ctl.conv_start |-> ##[1:17] ana_ctl.sar_tick;
   endproperty
   property p_irq_pulse;
      conv_irq |-> s_fin;
   endproperty
   property p_irq_en;
      conv_irq |-> $past(conv_irq_en);
   endproperty
   property p_start;
      ana_ctl.conv_start |=> !ana_ctl.conv_start;
   endproperty
   a_gain: assert property (p_gain) else $error("gain not one-hot");
   a_cfg_gap: assert property (p_cfg_gap) else $error("cfg gap bits");
   a_off: assert property (p_off) else $error("active while off");
   a_conv_hold: assert property (p_conv_hold) else $error("track");
   a_lp: assert property (p_lp) else $error("track in hold");
   a_tick: assert property (p_tick) else $error("no conv clock");
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq");
   a_irq_en: assert property (p_irq_en) else $error("irq masked");
   a_start: assert property (p_start) else $error("start width");
endmodule // sac_adc_ctrl_sva
bind sac_adc_ctrl sac_adc_ctrl_sva sac_adc_ctrl_sva_i (.core_clk(core_clk),
   .rst(rst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .conv_irq_en(conv_irq_en), .ana_ctl(ana_ctl), .conv_irq(conv_irq));

// ===== bench/tb.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
module tb
   import sac_pkg::*;
;
   // ========================================
   // Signals
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic t3 = 1'b0;
   logic t2 = 1'b0;
   logic pin = 1'b0;
   logic dm = 1'b0;
   logic win = 1'b0;
   logic ien = 1'b1;
   logic [9:0] code = 10'h000;
   logic [9:0] sar;
   logic [7:0] rdata;
   logic [7:0] d;
   logic [15:0] res;
   logic irq;
   sac_sfr_req_t req = '0;
   sac_ana_t ana;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int last = 0;
   int gap = 0;
   int n_tick = 0;
   int n_irq = 0;
   int n_trk = 0;
   always #5 core_clk = ~core_clk;
   sac_adc_ctrl sac_adc_ctrl_i (.core_clk(core_clk), .rst(rst), .ce(1'b1),
      .sfr_req(req), .sfr_rdata(rdata), .timer3_ovf(t3), .timer2_ovf(t2),
      .external_convert_start(pin), .diff_mode(dm), .window_hit(win),
      .conv_irq_en(ien), .sar_data(sar), .ana_ctl(ana), .result_word(res),
      .conv_irq(irq));
   sac_ana_model sac_ana_model_i (.ana_ctl(ana), .code(code), .sar_data(sar));
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (ana.sar_tick === 1'b1)
      begin
         gap <= cyc - last;
         last <= cyc;
         n_tick <= n_tick + 1;
      end
      if (irq === 1'b1) n_irq <= n_irq + 1;
      if (ana.track === 1'b1) n_trk <= n_trk + 1;
   end
   // ========================================
   // Shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step;
      @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      req = '{1'b1, 1'b0, a, v};
      step;
      req = '0;
      step;
   endtask
   task automatic rd(input logic [7:0] a);
      req = '{1'b0, 1'b1, a, 8'h00};
      step;
      req = '0;
      step;
      d = rdata;
   endtask
   task automatic idle;
      int i = 0;
      rd(8'hE8);
      while (d[4] !== 1'b0 && i < 300)
      begin
         rd(8'hE8);
         i++;
      end
      chk(16'(d[4]), 16'h0000);
   endtask
   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ========================================
   // Scenarios
   task automatic t_regs;
      rd(8'hBC);
      chk(16'(d), 16'h0060);
      rd(8'hE8);
      chk(16'(d), 16'h0000);
      rd(8'hBF);
      chk(16'(d), 16'h0000);
      rd(8'hC0);
      chk(16'(d), 16'h0000);
      wr(8'hBC, 8'hFF);
      rd(8'hBC);
      chk(16'(d), 16'h00E7);
      for (int g = 0; g < 8; g++)
      begin
         wr(8'hBC, 8'(g));
         chk(16'(ana.gain_sel),
            g < 4 ? 16'(1 << g) : 16'(g < 6 ? 16 : 32));
      end
      win = 1'b1;
      step;
      win = 1'b0;
      repeat (3) step;
      rd(8'hE8);
      chk(16'(d[1]), 16'h0001);
      wr(8'hE8, 8'h00);
      rd(8'hE8);
      chk(16'(d[1]), 16'h0000);
      $display("t_regs end");
   endtask
   task automatic t_track;
      int i;
      wr(8'hBC, 8'h00);
      wr(8'hE8, 8'h80);
      chk(16'(ana.track), 16'h0001);
      wr(8'hE8, 8'h00);
      chk(16'({ana.pwr_on, ana.track}), 16'h0000);
      wr(8'hE8, 8'hC8);
      repeat (4) step;
      chk(16'(ana.track), 16'h0001);
      pin = 1'b1;
      repeat (5) step;
      idle;
      chk(16'({ana.lp_hold, ana.track}), 16'h0002);
      pin = 1'b0;
      wr(8'hE8, 8'hC0);
      i = n_trk;
      wr(8'hE8, 8'hD0);
      idle;
      chk(16'(n_trk - i), 16'h0003);
      $display("t_track end");
   endtask
   task automatic t_trig;
      wr(8'hE8, 8'h84);
      wr(8'hE8, 8'h94);
      rd(8'hE8);
      chk(16'(d[4]), 16'h0000);
      t3 = 1'b1;
      step;
      t3 = 1'b0;
      rd(8'hE8);
      chk(16'(d[4]), 16'h0001);
      idle;
      wr(8'hE8, 8'h8C);
      t2 = 1'b1;
      step;
      t2 = 1'b0;
      rd(8'hE8);
      chk(16'(d[4]), 16'h0001);
      idle;
      wr(8'hE8, 8'h88);
      pin = 1'b1;
      repeat (5) step;
      rd(8'hE8);
      chk(16'(d[4]), 16'h0001);
      pin = 1'b0;
      idle;
      wr(8'hE8, 8'h80);
      $display("t_trig end");
   endtask
   task automatic conv(input logic [7:0] lj, input logic m,
      input logic [9:0] c, input logic [15:0] exp, input int dv);
      int k = n_tick;
      int q = n_irq;
      code = c;
      dm = m;
      wr(8'hE8, 8'h90 | lj);
      idle;
      chk(16'(n_tick - k), 16'h000B);
      chk(16'(gap), 16'(dv));
      chk(res, exp);
      rd(8'hBF);
      chk(16'(d), 16'(exp[15:8]));
      rd(8'hE8);
      chk(16'(d[5]), 16'h0001);
      chk(16'(n_irq - q), 16'(ien));
      wr(8'hE8, 8'h80 | lj);
      rd(8'hE8);
      chk(16'(d[5]), 16'h0000);
      $display("conv end");
   endtask
   // ========================================
   // Main sequence and watchdog
   initial
   begin
      repeat (2) @(posedge core_clk);
      #1 rst = 1'b0;
      t_regs;
      t_track;
      t_trig;
      for (int v = 0; v < 6; v++)
      begin
         wr(8'hBC, 8'(v << 5));
         conv(8'h00, 1'b0, 10'h2A5, 16'h02A5, v > 3 ? 16 : 1 << v);
      end
      wr(8'hBC, 8'h00);
      conv(8'h00, 1'b1, 10'h200, 16'hFE00, 1);
      conv(8'h01, 1'b1, 10'h200, 16'h8000, 1);
      conv(8'h00, 1'b1, 10'h3FF, 16'hFFFF, 1);
      conv(8'h01, 1'b1, 10'h3FF, 16'hFFC0, 1);
      conv(8'h01, 1'b0, 10'h1FF, 16'h7FC0, 1);
      ien = 1'b0;
      conv(8'h00, 1'b0, 10'h3FF, 16'h03FF, 1);
      wrap_up;
   end
   initial
   begin
      #300000;
      fail_count++;
      wrap_up;
   end
endmodule // tb
